//--- rtl/tgc_defines.vh
// Offsets, field positions, reset values and encodings for the timer gate block
`ifndef TGC_DEFINES_VH
`define TGC_DEFINES_VH
// Register byte offsets
`define TGC_CTRL_OFS 12'h000
`define TGC_GATE_OFS 12'h004
`define TGC_SENSE_OFS 12'h008
`define TGC_PERIOD_OFS 12'h00C
`define TGC_OPT_OFS 12'h010
`define TGC_COUNT_OFS 12'h014
`define TGC_T0_OFS 12'h018
`define TGC_T2_OFS 12'h01C
`define TGC_WDT_OFS 12'h020
// CTRL fields
`define TGC_CTRL_ON 0
`define TGC_CTRL_CS_LO 1
`define TGC_CTRL_CS_HI 2
`define TGC_CTRL_RST 32'h0000_0000
// GATE fields
`define TGC_GATE_GE 0
`define TGC_GATE_POL 1
`define TGC_GATE_SS_LO 2
`define TGC_GATE_SS_HI 3
`define TGC_GATE_SPM 4
`define TGC_GATE_GO 5
`define TGC_GATE_VAL 6
`define TGC_GATE_FLAG 7
// SENSE fields
`define TGC_SENSE_CH_LO 0
`define TGC_SENSE_CH_HI 3
`define TGC_SENSE_RNG_LO 4
`define TGC_SENSE_RNG_HI 5
`define TGC_SENSE_EN 6
`define TGC_SENSE_T0X 7
`define TGC_SENSE_OUT 8
// OPT fields
`define TGC_OPT_PS_LO 0
`define TGC_OPT_PS_HI 2
`define TGC_OPT_PSA 3
`define TGC_OPT_EIGHT_BIT_CLOCK_SELECT 5
`define TGC_OPT_RST 8'hFF
// Encodings
`define TGC_SS_PIN 2'h0
`define TGC_SS_T0 2'h1
`define TGC_SS_T2 2'h2
`define TGC_SS_WDT 2'h3
`define TGC_CS_OSC 2'h3
`define TGC_CS_EXT 2'h2
`define TGC_T0_MAX 8'hFF
`define TGC_PERIOD_RST 8'hFF
`define TGC_WDT_BASE_BITS 4
`endif

//--- rtl/tgc_timer_gate.v
// Sixteen-bit timer with gate count-enable logic and sensing oscillator hookup
`include "tgc_defines.vh"

module tgc_timer_gate (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire gate_pin_input,
  input wire ext_timer_clock_in,
  input wire sense_osc_in,
  input wire osc_direction_in,
  input wire wdt_clock_in,
  input wire clear_watchdog_instr,
  input wire sleep_instr,
  input wire wake_event,
  output reg [15:0] sense_channel_onehot,
  output reg [1:0] osc_current_range,
  output reg watchdog_run,
  output reg watchdog_reset_req
);

  // ****************************************
  // Synchronisers and edge finders
  // ****************************************
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg [4:0] sync3_r;
  wire gpin_s = sync2_r[0];
  wire gpin_rise = sync2_r[0] & ~sync3_r[0];
  wire eclk_rise = sync2_r[1] & ~sync3_r[1];
  wire osc_rise = sync2_r[2] & ~sync3_r[2];
  wire osc_dir_s = sync2_r[3];
  wire wclk_rise = sync2_r[4] & ~sync3_r[4];

  // Two flops before any logic; third flop only for edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
    end else begin
      sync1_r <= {wdt_clock_in, osc_direction_in, sense_osc_in, ext_timer_clock_in,
                  gate_pin_input};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  reg timer_on_r;
  reg [1:0] timer_clock_select_r;
  reg gate_count_enable_r;
  reg gate_polarity_r;
  reg [1:0] gate_source_select_r;
  reg gate_single_pulse_mode_r;
  reg gate_acquire_go_r;
  reg gate_event_flag_r;
  reg [3:0] sense_channel_select_r;
  reg [1:0] osc_range_r;
  reg sense_enable_r;
  reg cap_timer_select_r;
  reg [7:0] period_value_r;
  reg [7:0] option_r;
  reg [15:0] count_r;
  reg [7:0] eight_bit_timer_count_r;
  reg [7:0] period_timer_count_r;
  reg [15:0] watchdog_counter_r;
  reg gate_current_value_r;
  reg gate_val_d_r;

  // Offset match; shared by every writable register
  function tgc_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      tgc_hit = (addr == ofs);
    end
  endfunction

  // Write strobes, one per writable register word
  wire wr = psel & penable & pwrite;
  wire wr_ctrl = wr & tgc_hit(paddr, `TGC_CTRL_OFS);
  wire wr_gate = wr & tgc_hit(paddr, `TGC_GATE_OFS);
  wire wr_sense = wr & tgc_hit(paddr, `TGC_SENSE_OFS);
  wire wr_period = wr & tgc_hit(paddr, `TGC_PERIOD_OFS);
  wire wr_opt = wr & tgc_hit(paddr, `TGC_OPT_OFS);
  wire wr_count = wr & tgc_hit(paddr, `TGC_COUNT_OFS);

  // Single-cycle answer; unmapped offsets read zero with no error
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ****************************************
  // Gate sources
  // ****************************************
  // Eight-bit timer clock: sensing oscillator or the bus clock
  wire t0_tick = (cap_timer_select_r & ~option_r[`TGC_OPT_EIGHT_BIT_CLOCK_SELECT]) ? osc_rise : 1'b1;
  wire t0_wrap = t0_tick & (eight_bit_timer_count_r == `TGC_T0_MAX);
  wire t2_match = period_timer_count_r == period_value_r;
  wire t2_reset = t2_match;

  // Watchdog powered by gating even when timer is off
  wire wdt_gate_on = gate_count_enable_r & (gate_source_select_r == `TGC_SS_WDT);
  wire wdt_clear = clear_watchdog_instr | sleep_instr | wake_event;

  // Prescaler assigned to the watchdog stretches the interval
  function [15:0] tgc_wdt_limit;
    input [7:0] opt;
    begin
      if (opt[`TGC_OPT_PSA])
        tgc_wdt_limit = (16'h0001 << (`TGC_WDT_BASE_BITS + opt[2:0])) - 16'h0001;
      else
        tgc_wdt_limit = (16'h0001 << `TGC_WDT_BASE_BITS) - 16'h0001;
    end
  endfunction

  wire wdt_ovf = wclk_rise & (watchdog_counter_r == tgc_wdt_limit(option_r));

  // Raw source mux then polarity; one path per source
  reg gate_raw;
  always @* begin
    case (gate_source_select_r)
      `TGC_SS_PIN: gate_raw = gpin_s;
      `TGC_SS_T0: gate_raw = t0_wrap;
      `TGC_SS_T2: gate_raw = t2_reset;
      `TGC_SS_WDT: gate_raw = wdt_ovf;
      default: gate_raw = 1'b0;
    endcase
  end
  wire gate_qual = gate_polarity_r ? gate_raw : ~gate_raw;

  // ****************************************
  // Count enable and timer tick
  // ****************************************
  wire count_allow = timer_on_r & (~gate_count_enable_r | gate_qual);
  reg t1_tick;
  always @* begin
    case (timer_clock_select_r)
      `TGC_CS_OSC: t1_tick = osc_rise;
      `TGC_CS_EXT: t1_tick = eclk_rise;
      default: t1_tick = 1'b1;
    endcase
  end
  wire val_fall = gate_val_d_r & ~gate_current_value_r;
  wire spm_clr = gate_single_pulse_mode_r & val_fall;

  // ****************************************
  // Sequential state
  // ****************************************
  // Gate value pipeline; the delayed copy finds the falling edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_current_value_r <= 1'b0;
      gate_val_d_r <= 1'b0;
    end else begin
      gate_current_value_r <= gate_qual;
      gate_val_d_r <= gate_current_value_r;
    end
  end

  // Timer control and gate set-up, written only by software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_on_r <= 1'b0;
      timer_clock_select_r <= 2'h0;
      gate_count_enable_r <= 1'b0;
      gate_polarity_r <= 1'b0;
      gate_source_select_r <= 2'h0;
      gate_single_pulse_mode_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        timer_on_r <= pwdata[`TGC_CTRL_ON];
        timer_clock_select_r <= pwdata[`TGC_CTRL_CS_HI:`TGC_CTRL_CS_LO];
      end
      if (wr_gate) begin
        gate_count_enable_r <= pwdata[`TGC_GATE_GE];
        gate_polarity_r <= pwdata[`TGC_GATE_POL];
        gate_source_select_r <= pwdata[`TGC_GATE_SS_HI:`TGC_GATE_SS_LO];
        gate_single_pulse_mode_r <= pwdata[`TGC_GATE_SPM];
      end
    end
  end

  // Go bit and flag; hardware clear of go and hardware set of flag win
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_acquire_go_r <= 1'b0;
      gate_event_flag_r <= 1'b0;
    end else begin
      if (spm_clr)
        gate_acquire_go_r <= 1'b0;
      else if (wr_gate)
        gate_acquire_go_r <= pwdata[`TGC_GATE_GO];
      if (spm_clr & gate_acquire_go_r)
        gate_event_flag_r <= 1'b1;
      else if (wr_gate & pwdata[`TGC_GATE_FLAG])
        gate_event_flag_r <= 1'b0;
    end
  end

  // Sensing set-up; channel and range take effect on the outputs a cycle later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_channel_select_r <= 4'h0;
      osc_range_r <= 2'h0;
      sense_enable_r <= 1'b0;
      cap_timer_select_r <= 1'b0;
    end else begin
      if (wr_sense) begin
        sense_channel_select_r <= pwdata[`TGC_SENSE_CH_HI:`TGC_SENSE_CH_LO];
        osc_range_r <= pwdata[`TGC_SENSE_RNG_HI:`TGC_SENSE_RNG_LO];
        sense_enable_r <= pwdata[`TGC_SENSE_EN];
        cap_timer_select_r <= pwdata[`TGC_SENSE_T0X];
      end
    end
  end

  // Period and option words; a prescaler change mid-interval may cut it short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_value_r <= `TGC_PERIOD_RST;
      option_r <= `TGC_OPT_RST;
    end else begin
      if (wr_period)
        period_value_r <= pwdata[7:0];
      if (wr_opt)
        option_r <= pwdata[7:0];
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  // Main timer: a software load wins over a tick; holds while gated off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count_r <= 16'h0000;
    else if (wr_count)
      count_r <= pwdata[15:0];
    else if (count_allow & t1_tick)
      count_r <= count_r + 16'h0001;
  end

  // Eight-bit timer wraps freely; its wrap is a gate source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      eight_bit_timer_count_r <= 8'h00;
    else if (t0_tick)
      eight_bit_timer_count_r <= eight_bit_timer_count_r + 8'h01;
  end

  // Period timer resets on the increment after a match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      period_timer_count_r <= 8'h00;
    else if (t2_match)
      period_timer_count_r <= 8'h00;
    else
      period_timer_count_r <= period_timer_count_r + 8'h01;
  end

  // Watchdog restarts on any clear or on overflow; held at zero unless gated on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      watchdog_counter_r <= 16'h0000;
    else if (wdt_clear | ~wdt_gate_on | wdt_ovf)
      watchdog_counter_r <= 16'h0000;
    else if (wclk_rise)
      watchdog_counter_r <= watchdog_counter_r + 16'h0001;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Channel routing only while sensing is enabled; reset never raised by gating
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_channel_onehot <= 16'h0000;
      osc_current_range <= 2'h0;
      watchdog_run <= 1'b0;
      watchdog_reset_req <= 1'b0;
    end else begin
      sense_channel_onehot <= sense_enable_r ? (16'h0001 << sense_channel_select_r) :
                              16'h0000;
      osc_current_range <= osc_range_r;
      watchdog_run <= wdt_gate_on;
      watchdog_reset_req <= 1'b0;
    end
  end

  // Read mux
  always @* begin
    case (paddr)
      `TGC_CTRL_OFS: prdata = {29'h0, timer_clock_select_r, timer_on_r};
      `TGC_GATE_OFS: prdata = {24'h0, gate_event_flag_r, gate_current_value_r,
                               gate_acquire_go_r, gate_single_pulse_mode_r,
                               gate_source_select_r, gate_polarity_r, gate_count_enable_r};
      `TGC_SENSE_OFS: prdata = {23'h0, osc_dir_s, cap_timer_select_r, sense_enable_r,
                                osc_range_r, sense_channel_select_r};
      `TGC_PERIOD_OFS: prdata = {24'h0, period_value_r};
      `TGC_OPT_OFS: prdata = {24'h0, option_r};
      `TGC_COUNT_OFS: prdata = {16'h0, count_r};
      `TGC_T0_OFS: prdata = {24'h0, eight_bit_timer_count_r};
      `TGC_T2_OFS: prdata = {24'h0, period_timer_count_r};
      `TGC_WDT_OFS: prdata = {16'h0, watchdog_counter_r};
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule // tgc_timer_gate

//--- verif/tgc_gate_props.sv
// Port-level assertions for the timer gate block
`include "tgc_defines.vh"
module tgc_gate_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [15:0] sense_channel_onehot,
  input wire [1:0] osc_current_range,
  input wire watchdog_run,
  input wire watchdog_reset_req
);
  // ****
  // Decode
  // ****
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire wr_gate = wr && paddr == `TGC_GATE_OFS;
  wire wr_sense = wr && paddr == `TGC_SENSE_OFS;
  reg [31:0] gate_r;
  reg [31:0] sense_r;
  // Held copies, so an output that lags a cycle can still be judged
  always @(posedge pclk) begin
    if (wr_gate) gate_r <= pwdata;
    if (wr_sense) sense_r <= pwdata;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_run_follows: assert property (wr_gate |-> ##[1:2]
    watchdog_run == (gate_r[0] && gate_r[3:2] == 2'h3)) else $error("run wrong");
  a_run_holds: assert property (!wr_gate [*2] |=> $stable(watchdog_run))
    else $error("run moved");
  a_run_vs_reg: assert property (rd && paddr == `TGC_GATE_OFS |->
    watchdog_run == (prdata[0] && prdata[3:2] == 2'h3)) else $error("run mismatch");
  a_no_wdt_reset: assert property (!watchdog_reset_req) else $error("reset req");
  a_chan_follows: assert property (wr_sense |-> ##[1:2] sense_channel_onehot ==
    (sense_r[6] ? 16'h1 << sense_r[3:0] : 16'h0)) else $error("channel wrong");
  a_chan_holds: assert property (!wr_sense [*2] |=> $stable(sense_channel_onehot))
    else $error("channel moved");
  a_range_follows: assert property (wr_sense |-> ##[1:2]
    osc_current_range == sense_r[5:4]) else $error("range wrong");
  a_range_vs_reg: assert property (rd && paddr == `TGC_SENSE_OFS |->
    prdata[5:4] == osc_current_range) else $error("range mismatch");
endmodule // tgc_gate_props
bind tgc_timer_gate tgc_gate_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .sense_channel_onehot, .osc_current_range, .watchdog_run,
  .watchdog_reset_req);

//--- verif/tgc_far_model.sv
// Far-side model: sensing oscillator, its direction status, watchdog oscillator
module tgc_far_model (
  output logic sense_osc_in,
  output logic osc_direction_in,
  output logic wdt_clock_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Oscillators
  // ****
  // Watchdog oscillator runs free, unrelated to the bus clock
  initial begin
    wdt_clock_in = 1'h0;
    forever #15 wdt_clock_in = ~wdt_clock_in;
  end
  // Sensing oscillator rests low between bursts, so no stray edge is counted
  initial begin
    sense_osc_in = 1'h0;
    osc_direction_in = 1'h0;
  end
  // Status reads sourcing on the rising ramp, sinking on the falling one
  task automatic osc_burst(input int n);
    repeat (n) begin
      #24;
      sense_osc_in = 1'h1;
      osc_direction_in = 1'h1;
      #24;
      sense_osc_in = 1'h0;
      osc_direction_in = 1'h0;
    end
  endtask
  // Parks the oscillator so its status can be read
  task automatic osc_hold(input logic v);
    sense_osc_in = v;
    osc_direction_in = v;
  endtask
endmodule // tgc_far_model

//--- verif/tb_top.sv
// Self-checking bench for the timer gate block
`include "tgc_defines.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic gate_pin_input = 0;
  logic ext_clk = 0;
  logic [2:0] wclr = 3'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire [15:0] sense_channel_onehot;
  wire [1:0] osc_current_range;
  wire pready, pslverr, sense_osc_in, osc_direction_in, wdt_clock_in;
  wire watchdog_run, watchdog_reset_req;
  typedef struct {logic [31:0] lo; logic [31:0] hi; logic [31:0] m;} tgc_note_t;
  tgc_note_t notes[$];
  tgc_note_t cur;
  int n_fail = 0;
  int num_checks = 0;
  int n;
  logic [3:0] cases [0:6] = '{4'h9, 4'h7, 4'h0, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [31:0] lo3 [0:4] = '{32'h3, 32'h64, 32'h0, 32'h9, 32'h4};
  logic [31:0] hi3 [0:4] = '{32'h6, 32'h6A, 32'h0, 32'hC, 32'h7};
  logic [31:0] gv [0:2] = '{32'hD, 32'hC, 32'h1};
  logic [31:0] e;
  logic [3:0] c;
  logic [1:0] rg;
  logic en;
  tgc_timer_gate uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .gate_pin_input, .ext_timer_clock_in(ext_clk), .sense_osc_in,
    .osc_direction_in, .wdt_clock_in, .clear_watchdog_instr(wclr[0]), .sleep_instr(wclr[1]),
    .wake_event(wclr[2]), .sense_channel_onehot, .osc_current_range, .watchdog_run,
    .watchdog_reset_req);
  tgc_far_model far (.sense_osc_in, .osc_direction_in, .wdt_clock_in);
  // ****
  // Clock, hang guard, read monitor, bus tasks
  // ****
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Run is about 7k cycles; far beyond that means a hang
  initial begin
    #400us;
    n_fail++;
    stop_test();
  end
  // Each finished read retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && notes.size() > 0) begin
      cur = notes.pop_front();
      `CHK((prdata & cur.m) >= cur.lo && (prdata & cur.m) <= cur.hi, 1'h1)
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k == 20) begin
      n_fail++;
      stop_test();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] m);
    notes.push_back('{lo, hi, m});
    apb(1'h0, a, 32'h0);
  endtask
  // Outputs are looked at mid-cycle, clear of the edge updates
  task automatic settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(82945));
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(`TGC_CTRL_OFS, 32'h0, 32'h0, 32'hFFFF_FFFF);
    rd(`TGC_GATE_OFS, 32'h0, 32'h0, 32'hBF);
    rd(`TGC_OPT_OFS, 32'hFF, 32'hFF, 32'hFF);
    rd(12'h100, 32'h0, 32'h0, 32'hFFFF_FFFF);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      c = cases[i];
      n = 1 + $urandom % 8;
      e = (c[3] && (!c[2] || c[1] == c[0])) ? 32'(n) : 32'h0;
      gate_pin_input <= c[0];
      wr(`TGC_GATE_OFS, {30'h0, c[1], c[2]});
      wr(`TGC_COUNT_OFS, 32'h0);
      wr(`TGC_CTRL_OFS, {29'h0, 2'h3, c[3]});
      far.osc_burst(n);
      repeat (6) @(posedge pclk);
      rd(`TGC_COUNT_OFS, e, e, 32'hFFFF);
      wr(`TGC_CTRL_OFS, 32'h0);
    end
    $display("test gate table done");
    wr(`TGC_PERIOD_OFS, 32'h9);
    for (int i = 0; i < 5; i++) begin
      if (i == 2) begin
        wr(`TGC_SENSE_OFS, 32'h80);
        wr(`TGC_OPT_OFS, 32'hDF);
      end
      if (i == 3) wr(`TGC_OPT_OFS, 32'hF7);
      if (i == 4) wr(`TGC_OPT_OFS, 32'hF9);
      wr(`TGC_GATE_OFS, i == 1 ? 32'hB : (i > 2 ? 32'hF : 32'h7));
      wr(`TGC_COUNT_OFS, 32'h0);
      wr(`TGC_CTRL_OFS, 32'h1);
      repeat (1024) @(posedge pclk);
      wr(`TGC_CTRL_OFS, 32'h0);
      rd(`TGC_COUNT_OFS, lo3[i], hi3[i], 32'hFFFF);
    end
    $display("test event sources done");
    wclr <= 3'(1 << ($urandom % 3));
    repeat (50) @(posedge pclk);
    rd(`TGC_WDT_OFS, 32'h0, 32'h0, 32'hFFFF);
    wclr <= 3'h0;
    repeat (100) @(posedge pclk);
    rd(`TGC_WDT_OFS, 32'h1, 32'h1F, 32'hFFFF);
    $display("test watchdog clear done");
    wr(`TGC_OPT_OFS, 32'hF7);
    for (int j = 0; j < 3; j++) begin
      wr(`TGC_GATE_OFS, gv[j]);
      settle();
      `CHK(watchdog_run, gv[j] == 32'hD)
      repeat (300) @(negedge pclk);
      `CHK(watchdog_reset_req, 1'h0)
      @(posedge pclk);
    end
    $display("test watchdog done");
    gate_pin_input <= 1'h0;
    wr(`TGC_GATE_OFS, 32'h13);
    wr(`TGC_GATE_OFS, 32'h33);
    rd(`TGC_GATE_OFS, 32'h20, 32'h20, 32'hA0);
    gate_pin_input <= 1'h1;
    repeat (5) @(posedge pclk);
    gate_pin_input <= 1'h0;
    repeat (5) @(posedge pclk);
    rd(`TGC_GATE_OFS, 32'h80, 32'h80, 32'hA0);
    wr(`TGC_GATE_OFS, 32'h93);
    rd(`TGC_GATE_OFS, 32'h0, 32'h0, 32'hA0);
    $display("test single pulse done");
    for (int ch = 0; ch < 16; ch++) begin
      en = 1'($urandom % 2);
      rg = 2'($urandom % 4);
      wr(`TGC_SENSE_OFS, {25'h0, en, rg, ch[3:0]});
      settle();
      `CHK(sense_channel_onehot, en ? 16'h1 << ch : 16'h0)
      `CHK(osc_current_range, rg)
      @(posedge pclk);
    end
    $display("test channels done");
    for (int v = 0; v < 2; v++) begin
      far.osc_hold(v[0]);
      repeat (6) @(posedge pclk);
      rd(`TGC_SENSE_OFS, 32'(v) << 8, 32'(v) << 8, 32'h100);
    end
    $display("test direction done");
    wr(`TGC_GATE_OFS, 32'h0);
    wr(`TGC_COUNT_OFS, 32'h0);
    wr(`TGC_CTRL_OFS, 32'h5);
    n = 1 + $urandom % 8;
    repeat (n) begin
      ext_clk <= 1'h1;
      repeat (4) @(posedge pclk);
      ext_clk <= 1'h0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    rd(`TGC_COUNT_OFS, 32'(n), 32'(n), 32'hFFFF);
    wr(`TGC_CTRL_OFS, 32'h0);
    $display("test external clock done");
    stop_test();
  end
endmodule // tb_top
